// [verilog/sop_array_defines.svh]
// Constants of the sum-of-products logic array: sizes, term indexes,
// register offsets and field positions.
// Assumes inclusion by bare name from the package and the design file.
`ifndef SOP_ARRAY_DEFINES_SVH
`define SOP_ARRAY_DEFINES_SVH

`define N_IN            12
`define N_IO            10
`define N_LINES         44
`define N_TERMS         92
`define TERMS_PER_CELL  8
`define OE_TERM_BASE    80
`define PRESET_TERM     90
`define CLEAR_TERM      91
`define CFG_BITS        4
`define CELLS_PER_WORD  8
`define SIG_W           24
`define LOW_W           32
`define HIGH_W          12

`define ADDR_W          12
`define OFS_CTRL        12'h000
`define OFS_STATUS      12'h004
`define OFS_SIGNATURE   12'h008
`define OFS_MCFG0       12'h00C
`define OFS_MCFG1       12'h010
`define OFS_TERM_BASE   12'h100
`define TERM_STRIDE_SH  3

`define CTRL_RUN_BIT    0
`define CTRL_ERASE_BIT  1
`define CTRL_LOCK_BIT   2
`define STAT_LOCK_BIT   0
`define STAT_RUN_BIT    1
`define STAT_Q_LSB      16

`define ZERO_WORD       32'h0000_0000
`define HTRANS_NONSEQ   2'h2

`endif

// [verilog/sop_array_pkg.sv]
// Types shared by the logic array design.
// Assumes the defines header is on the include path.
`include "sop_array_defines.svh"

package sop_array_pkg;

   // Macrocell configuration bits A B C D
   typedef struct packed {
      logic pol_high;
      logic out_comb;
      logic sel_c;
      logic sel_d;
   } mcell_cfg_t;

   // Captured AHB address phase
   typedef struct packed {
      logic                 valid;
      logic                 write;
      logic [`ADDR_W-1:0]   addr;
   } ahb_phase_t;

   typedef logic [`N_LINES-1:0] conn_row_t;

endpackage

// [verilog/sop_array.sv]
// Programmable AND / fixed OR logic array with ten I/O macrocells,
// configured over an AHB-Lite slave port.
// Assumes one 100 MHz clock; pins come from outside and are synchronised.
//
// Function
// R1 - Twelve input pins and ten I/O pins; ten sum-of-products outputs.
// R2 - Twenty-four array lines carry true and inverted input pins.
// R3 - Twenty more lines carry true and inverted macrocell feedback.
// R4 - Eighty sum terms, eight per cell, ten enables, preset, clear.
// R5 - Term tied to true and inverted line of one signal is false.
// R6 - Term with every connection open is always true.
// R7 - Bulk erase opens every connection, making every term true.
// R8 - Each cell: one D flip-flop, two selectors, four config bits.
// R9 - Output is OR result or flip-flop, either polarity.
// R10 - Flip-flop captures OR result on each rising clock edge.
// R11 - Preset term true sets every flip-flop high at next edge.
// R12 - Clear term true forces every flip-flop low at once.
// R13 - Clear wins when clear and preset are both true.
// R14 - Pin driven only while its output enable term is true.
// R15 - Open enable term drives always; fully connected never drives. Here an open term drives only while run_ff is set.
// R16 - Feedback comes from pin, flip-flop or OR gate.
// R17 - OR feedback available in any output mode, even disabled.
// R18 - Register feedback available while pin shows OR result.
// R19 - Security lock refuses readback and programming until bulk erase.
// R20 - Twenty-four-bit signature stays readable while locked.
// R21 - Config code: A is polarity, BCD selects output and feedback.
// R22 - Connections and config are static, loaded before logic runs.
//
// Decided for this implementation: register access over AHB-Lite and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "sop_array_defines.svh"

module sop_array (
   input  wire logic                 CLK_I,
   input  wire logic                 RST_N_I,
   input  wire logic                 HSEL_I,
   input  wire logic [`ADDR_W-1:0]   HADDR_I,
   input  wire logic [1:0]           HTRANS_I,
   input  wire logic                 HWRITE_I,
   input  wire logic [2:0]           HSIZE_I,
   input  wire logic [31:0]          HWDATA_I,
   input  wire logic                 HREADY_I,
   output logic                      HREADYOUT_O,
   output logic                      HRESP_O,
   output logic [31:0]               HRDATA_O,
   input  wire logic [`N_IN-1:0]     IN_I,
   input  wire logic [`N_IO-1:0]     IO_IN_I,
   output logic [`N_IO-1:0]          IO_OUT_O,
   output logic [`N_IO-1:0]          IO_OE_O
);
   import sop_array_pkg::*;

   // ---------------- Pin synchronisers ----------------
   logic [`N_IN-1:0]    in_meta_ff;
   logic [`N_IN-1:0]    in_sync_ff;
   logic [`N_IO-1:0]    io_meta_ff;
   logic [`N_IO-1:0]    io_sync_ff;

   always_ff @(posedge CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         in_meta_ff <= '0;
         in_sync_ff <= '0;
         io_meta_ff <= '0;
         io_sync_ff <= '0;
      end else begin
         in_meta_ff <= IN_I;
         in_sync_ff <= in_meta_ff;
         io_meta_ff <= IO_IN_I;
         io_sync_ff <= io_meta_ff;
      end
   end

   // ---------------- AHB-Lite slave ----------------
   ahb_phase_t          ph_ff;
   ahb_phase_t          nxt_ph;
   logic                rd_wait_ff;
   logic [31:0]         hrdata_ff;
   logic [31:0]         rd_data;
   wire                 accept   = HSEL_I & HREADY_I & HTRANS_I[1];
   wire                 wr_en    = ph_ff.valid & ph_ff.write;
   wire [`ADDR_W-1:0]   wa       = ph_ff.addr;

   always_comb begin
      nxt_ph = ph_ff;
      if (accept) begin
         nxt_ph.valid = 1'b1;
         nxt_ph.write = HWRITE_I;
         nxt_ph.addr  = {HADDR_I[`ADDR_W-1:2], 2'b00};
      end else if (HREADY_I) begin
         nxt_ph.valid = 1'b0;
      end
   end

   // Reads take one wait state so a write just before is already visible
   always_ff @(posedge CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         ph_ff      <= '0;
         rd_wait_ff <= 1'b0;
         hrdata_ff  <= `ZERO_WORD;
      end else begin
         ph_ff      <= nxt_ph;
         rd_wait_ff <= accept & ~HWRITE_I;
         if (rd_wait_ff) begin
            hrdata_ff <= rd_data;
         end
      end
   end

   assign HREADYOUT_O = ~rd_wait_ff;
   assign HRESP_O     = 1'b0;
   assign HRDATA_O    = hrdata_ff;

   // ---------------- Control state ----------------
   logic                run_ff;
   logic                lock_ff;
   logic [`SIG_W-1:0]   sig_ff;
   wire                 ctrl_wr  = wr_en & (wa == `OFS_CTRL);
   wire                 erase    = ctrl_wr & HWDATA_I[`CTRL_ERASE_BIT];
   // Programming is refused while locked or while the logic runs
   wire                 prog_ok  = ~lock_ff & ~run_ff;                 // [R19] [R22]

   always_ff @(posedge CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         run_ff  <= 1'b0;
         lock_ff <= 1'b0;
         sig_ff  <= '0;
      end else begin
         if (ctrl_wr) begin
            run_ff <= HWDATA_I[`CTRL_RUN_BIT];
         end
         if (erase) begin
            lock_ff <= 1'b0;                                           // [R19]
            sig_ff  <= '0;
         end else begin
            if (ctrl_wr && HWDATA_I[`CTRL_LOCK_BIT]) begin
               lock_ff <= 1'b1;
            end
            if (wr_en && (wa == `OFS_SIGNATURE) && !lock_ff) begin
               sig_ff <= HWDATA_I[`SIG_W-1:0];
            end
         end
      end
   end

   // ---------------- Connection memory ----------------
   conn_row_t           conn_ff [`N_TERMS];
   wire                 term_area = (wa >= `OFS_TERM_BASE);
   wire [`ADDR_W-1:0]   term_ofs  = wa - `OFS_TERM_BASE;
   wire [`ADDR_W-1:0]   term_idx  = term_ofs >> `TERM_STRIDE_SH;
   wire                 term_hi   = wa[2];
   wire                 term_wr   = wr_en & term_area & prog_ok;

   genvar t;
   generate
      for (t = 0; t < `N_TERMS; t++) begin : g_row
         wire sel = term_wr & (term_idx == `ADDR_W'(t));
         always_ff @(posedge CLK_I or negedge RST_N_I) begin
            if (!RST_N_I) begin
               conn_ff[t] <= '0;
            end else if (erase) begin
               conn_ff[t] <= '0;                                       // [R7]
            end else if (sel && term_hi) begin
               conn_ff[t][`N_LINES-1:`LOW_W] <= HWDATA_I[`HIGH_W-1:0];
            end else if (sel) begin
               conn_ff[t][`LOW_W-1:0] <= HWDATA_I;
            end
         end
      end
   endgenerate

   // ---------------- Macrocell configuration ----------------
   mcell_cfg_t          cfg_ff [`N_IO];
   wire                 cfg0_wr = wr_en & prog_ok & (wa == `OFS_MCFG0);
   wire                 cfg1_wr = wr_en & prog_ok & (wa == `OFS_MCFG1);

   genvar c;
   generate
      for (c = 0; c < `N_IO; c++) begin : g_cfg
         localparam int SLOT = (c % `CELLS_PER_WORD) * `CFG_BITS;
         wire sel = (c < `CELLS_PER_WORD) ? cfg0_wr : cfg1_wr;
         always_ff @(posedge CLK_I or negedge RST_N_I) begin
            if (!RST_N_I) begin
               cfg_ff[c] <= '0;
            end else if (erase) begin
               cfg_ff[c] <= '0;
            end else if (sel) begin
               cfg_ff[c] <= HWDATA_I[SLOT +: `CFG_BITS];                // [R8]
            end
         end
      end
   endgenerate

   // ---------------- AND array ----------------
   logic [`N_IO-1:0]    fb;
   wire  [`N_IN+`N_IO-1:0] sig_in = {fb, in_sync_ff};
   logic [`N_LINES-1:0] lines;
   logic [`N_TERMS-1:0] term;

   genvar s;
   generate
      // Even line true, odd line inverted
      for (s = 0; s < `N_IN + `N_IO; s++) begin : g_line
         assign lines[2*s]   = sig_in[s];                              // [R2] [R3]
         assign lines[2*s+1] = ~sig_in[s];                             // [R2] [R3]
      end
      // Open connection is a don't care; true and inverted together is false
      for (t = 0; t < `N_TERMS; t++) begin : g_term
         assign term[t] = &(~conn_ff[t] | lines);                      // [R5] [R6]
      end
   endgenerate

   wire preset = term[`PRESET_TERM];                                   // [R4]
   wire clear  = term[`CLEAR_TERM];                                    // [R4]

   // ---------------- Macrocells ----------------
   logic [`N_IO-1:0]    or_sum;
   logic [`N_IO-1:0]    q_ff;
   logic [`N_IO-1:0]    nxt_q;
   logic [`N_IO-1:0]    q_vis;
   logic [`N_IO-1:0]    comb_fb_ff;

   generate
      for (c = 0; c < `N_IO; c++) begin : g_cell
         wire       fb_pin;
         wire       fb_reg;
         wire       out_val;
         assign or_sum[c] = |term[c*`TERMS_PER_CELL +: `TERMS_PER_CELL]; // [R1] [R4]
         assign nxt_q[c]  = clear  ? 1'b0 :                            // [R13]
                            preset ? 1'b1 :                            // [R11]
                            or_sum[c];                                 // [R10]
         // Clear shows on the register output without waiting for an edge
         assign q_vis[c]  = q_ff[c] & ~clear;                          // [R12]
         // D selects OR feedback; otherwise B xor C selects pin over register
         assign fb_pin    = cfg_ff[c].out_comb ^ cfg_ff[c].sel_c;      // [R21]
         assign fb_reg    = ~cfg_ff[c].sel_d & ~fb_pin;
         assign fb[c]     = cfg_ff[c].sel_d ? comb_fb_ff[c] :          // [R16] [R17]
                            fb_reg          ? q_vis[c] :               // [R18]
                            io_sync_ff[c];
         assign out_val   = cfg_ff[c].out_comb ? or_sum[c] : q_vis[c]; // [R9] [R21]
         assign IO_OUT_O[c] = cfg_ff[c].pol_high ? out_val : ~out_val;  // [R9] [R21]
         // Enable term open: on while run_ff is set; fully connected: pin is an input
         assign IO_OE_O[c] = term[`OE_TERM_BASE + c] & run_ff;         // [R14] [R15] [R22]
      end
   endgenerate

   // OR feedback passes one flop so the OR gate never closes a zero-delay loop
   always_ff @(posedge CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         q_ff       <= '0;
         comb_fb_ff <= '0;
      end else begin
         q_ff       <= nxt_q;                                          // [R10]
         comb_fb_ff <= or_sum;                                         // [R17]
      end
   end

   // ---------------- Read mux ----------------
   logic [31:0]         mcfg0_word;
   logic [31:0]         mcfg1_word;
   wire  [`ADDR_W-1:0]  ra       = ph_ff.addr;
   wire  [`ADDR_W-1:0]  ra_ofs   = ra - `OFS_TERM_BASE;
   wire  [`ADDR_W-1:0]  ra_idx   = ra_ofs >> `TERM_STRIDE_SH;
   wire                 ra_term  = (ra >= `OFS_TERM_BASE) && (ra_idx < `N_TERMS);
   wire  [6:0]          ra_sel   = ra_idx[6:0];
   wire  [31:0]         term_word = ra[2] ?
                        {{(32-`HIGH_W){1'b0}}, conn_ff[ra_sel][`N_LINES-1:`LOW_W]} :
                        conn_ff[ra_sel][`LOW_W-1:0];
   wire  [31:0]         status_word;

   generate
      for (c = 0; c < `CELLS_PER_WORD; c++) begin : g_rd0
         assign mcfg0_word[c*`CFG_BITS +: `CFG_BITS] = cfg_ff[c];
      end
      for (c = `CELLS_PER_WORD; c < `N_IO; c++) begin : g_rd1
         assign mcfg1_word[(c-`CELLS_PER_WORD)*`CFG_BITS +: `CFG_BITS] = cfg_ff[c];
      end
   endgenerate
   assign mcfg1_word[31:(`N_IO-`CELLS_PER_WORD)*`CFG_BITS] = '0;

   assign status_word = {{(32-`STAT_Q_LSB-`N_IO){1'b0}}, q_vis,
                         {(`STAT_Q_LSB-2){1'b0}}, run_ff, lock_ff};

   // Locked parts read as zero; signature and status stay visible
   always_comb begin
      rd_data = `ZERO_WORD;
      if (ra == `OFS_CTRL) begin
         rd_data = {{31{1'b0}}, run_ff};
      end else if (ra == `OFS_STATUS) begin
         rd_data = status_word;
      end else if (ra == `OFS_SIGNATURE) begin
         rd_data = {{(32-`SIG_W){1'b0}}, sig_ff};                       // [R20]
      end else if (lock_ff) begin
         rd_data = `ZERO_WORD;                                         // [R19]
      end else if (ra == `OFS_MCFG0) begin
         rd_data = mcfg0_word;
      end else if (ra == `OFS_MCFG1) begin
         rd_data = mcfg1_word;
      end else if (ra_term) begin
         rd_data = term_word;
      end
   end

endmodule
`default_nettype wire

// [verification/sop_array_assertions.sv]
// Bus and pin checks for the logic array, seen from its top ports.
// Assumes one AHB-Lite master that never overlaps two transfers.
`timescale 1ns/1ps
`default_nettype none
`include "sop_array_defines.svh"
module sop_array_chk (
   input wire logic               CLK_I,
   input wire logic               RST_N_I,
   input wire logic               HSEL_I,
   input wire logic [`ADDR_W-1:0] HADDR_I,
   input wire logic [1:0]         HTRANS_I,
   input wire logic               HWRITE_I,
   input wire logic [31:0]        HWDATA_I,
   input wire logic               HREADY_I,
   input wire logic               HREADYOUT_O,
   input wire logic               HRESP_O,
   input wire logic [31:0]        HRDATA_O,
   input wire logic [`N_IO-1:0]   IO_OE_O
);
   logic        wr_ff, run_ff, lock_ff;
   logic [11:0] adr_ff;
   logic [23:0] sig_ff;
   logic [31:0] cfg_ff;
   wire         take = HSEL_I & HREADY_I & HTRANS_I[1];
   wire         rd = take & !HWRITE_I;
   wire  [11:0] ra = HADDR_I & 12'hFFC;
   wire         wctl = wr_ff && adr_ff == `OFS_CTRL;
   wire         erase = wctl && HWDATA_I[1];
   // Shadow of the control, signature and first config word
   always_ff @(posedge CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         {wr_ff, run_ff, lock_ff, adr_ff, sig_ff, cfg_ff} <= '0;
      end else begin
         wr_ff <= take & HWRITE_I;
         if (take) adr_ff <= ra;
         if (wctl) run_ff <= HWDATA_I[0];
         if (wctl) lock_ff <= !HWDATA_I[1] & (lock_ff | HWDATA_I[2]);
         if (erase) sig_ff <= '0;
         else if (wr_ff && adr_ff == `OFS_SIGNATURE && !lock_ff) sig_ff <= HWDATA_I[23:0];
         if (erase) cfg_ff <= '0;
         else if (wr_ff && adr_ff == `OFS_MCFG0 && !lock_ff && !run_ff) cfg_ff <= HWDATA_I;
      end
   end
   default clocking cb @(posedge CLK_I); endclocking
   default disable iff (!RST_N_I);
   chk_oe_needs_run: assert property (!run_ff |-> IO_OE_O == 10'h000)
      else $error("pin enabled while stopped");
   chk_read_wait: assert property (rd |=> !HREADYOUT_O ##1 HREADYOUT_O)
      else $error("read wait state wrong");
   chk_write_fast: assert property (take && HWRITE_I |=> HREADYOUT_O)
      else $error("write stalled");
   chk_resp_okay: assert property (HRESP_O == 1'b0)
      else $error("error response");
   chk_lock_hides: assert property (rd && ra == `OFS_MCFG0 && lock_ff |=> ##1
      HRDATA_O == `ZERO_WORD) else $error("config readable while locked");
   chk_sig_kept: assert property (rd && ra == `OFS_SIGNATURE |=> ##1
      HRDATA_O == {8'h00, sig_ff}) else $error("signature wrong");
   chk_cfg_kept: assert property (rd && ra == `OFS_MCFG0 && !lock_ff |=> ##1
      HRDATA_O == cfg_ff) else $error("config word wrong");
   chk_stat_flags: assert property (rd && ra == `OFS_STATUS |=> ##1
      HRDATA_O[1:0] == {run_ff, lock_ff}) else $error("status flags wrong");
endmodule
bind sop_array sop_array_chk chk_u (.*);
`default_nettype wire

// [verification/board_model.sv]
// Board logic around the array: input pins and the shared I/O pins.
// Assumes the bench sets the wanted input levels after a clock edge.
`timescale 1ns/1ps
`default_nettype none
module board_model (
   input  wire logic        CLK_I,
   input  wire logic [11:0] in_want_i,
   input  wire logic [9:0]  io_out_i,
   input  wire logic [9:0]  io_oe_i,
   output logic [11:0]      in_o,
   output logic [9:0]       io_in_o
);
   logic [9:0] idle_ff = 10'h155;
   always_ff @(posedge CLK_I) idle_ff <= ~idle_ff;
   assign in_o = in_want_i;
   // A released pin shows a toggling pattern, not the last driven level
   assign io_in_o = (io_oe_i & io_out_i) | (~io_oe_i & idle_ff);
endmodule
`default_nettype wire

// [verification/testbench.sv]
// Self-checking bench for the logic array: registers, pins, refusals.
// Assumes the array design, its defines header and the board model.
`timescale 1ns/1ps
`default_nettype none
`include "sop_array_defines.svh"
module testbench;
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic        hsel = 1'b0;
   logic        hwrite = 1'b0;
   logic        pin_chk = 1'b0;
   logic        rd_ph = 1'b0;
   logic [1:0]  htrans = 2'h0;
   logic [11:0] haddr = 12'h000;
   logic [31:0] hwdata = `ZERO_WORD;
   logic [11:0] in_want = 12'h000;
   logic        hready, hresp;
   logic [31:0] hrdata, seed, r, sig;
   logic [11:0] in_pins;
   logic [9:0]  io_in, io_out, io_oe;
   logic [43:0] exp_w[$];
   logic [19:0] exp_p[$];
   int          num_errors = 0;
   int          checks_done = 0;
   int          cycles = 0;

   always #5 clk = ~clk;

   sop_array dut_u (.CLK_I(clk), .RST_N_I(rst_n), .HSEL_I(hsel), .HADDR_I(haddr),
      .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(3'h2), .HWDATA_I(hwdata),
      .HREADY_I(hready), .HREADYOUT_O(hready), .HRESP_O(hresp), .HRDATA_O(hrdata),
      .IN_I(in_pins), .IO_IN_I(io_in), .IO_OUT_O(io_out), .IO_OE_O(io_oe));
   board_model board_u (.CLK_I(clk), .in_want_i(in_want), .io_out_i(io_out),
      .io_oe_i(io_oe), .in_o(in_pins), .io_in_o(io_in));

   task automatic wrap_up();
      $display("checks %0d errors %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask

   task automatic cmp_word(input logic [43:0] e, input logic [31:0] g);
      checks_done++;
      if (g !== e[31:0]) begin
         num_errors++;
         $display("wrong value reg %h expected %h seen %h", e[43:32], e[31:0], g);
      end
   endtask

   task automatic cmp_pins(input logic [19:0] e, input logic [19:0] g);
      checks_done++;
      if (g !== e) begin
         num_errors++;
         $display("wrong value pins expected %h seen %h", e, g);
      end
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic w = 1'b1);
      hsel <= 1'b1;
      htrans <= `HTRANS_NONSEQ;
      hwrite <= w;
      haddr <= a;
      do @(posedge clk); while (!hready);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clk); while (!hready);
   endtask

   task automatic rd(input logic [11:0] a, input logic [31:0] e);
      exp_w.push_back({a, e});
      wr(a, `ZERO_WORD, 1'b0);
   endtask

   task automatic pins(input logic [19:0] e);
      repeat (8) @(posedge clk);
      exp_p.push_back(e);
      pin_chk <= 1'b1;
      @(posedge clk);
      pin_chk <= 1'b0;
   endtask

   function automatic logic [11:0] ta(input int t);
      return `OFS_TERM_BASE + 12'(t << `TERM_STRIDE_SH);
   endfunction

   // Result watcher and hang guard
   always @(posedge clk) begin
      cycles++;
      if (cycles == 4000) begin
         num_errors++;
         wrap_up();
      end
      if (rd_ph && hready) cmp_word(exp_w.pop_front(), hrdata);
      if (pin_chk) cmp_pins(exp_p.pop_front(), {io_oe, io_out});
      if (hready) rd_ph <= htrans[1] & !hwrite;
   end

   initial begin
      seed = 32'h11b3_fa63;
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      pins({10'h000, 10'h3FF});
      rd(`OFS_STATUS, `ZERO_WORD);
      sig = $random(seed);
      wr(`OFS_SIGNATURE, sig);
      rd(`OFS_SIGNATURE, {8'h00, sig[23:0]});
      for (int t = 0; t < 80; t++) wr(ta(t), t == 0 ? 32'h0000_0001 : t == 8 ?
         32'h0000_0004 : t == 16 ? 32'h0400_0000 : t == 24 ? 32'h0000_0004 :
         t == 32 ? 32'h4000_0000 : 32'h0000_0003);
      wr(ta(91), 32'h0000_0003);
      rd(`OFS_STATUS, 32'h03FF_0000);
      wr(ta(90), 32'h0000_0003);
      wr(`OFS_MCFG0, 32'h000E_FEAC);
      wr(`OFS_CTRL, 32'h0000_0001);
      repeat (4) begin
         r = $random(seed);
         in_want <= r[11:0];
         pins({10'h3FF, 5'h1F, {4{r[1]}}, r[0]});
         rd(`OFS_STATUS, {6'h00, 5'h00, {4{r[1]}}, r[0], 14'h0000, 2'h2});
      end
      wr(`OFS_MCFG0, `ZERO_WORD);
      rd(`OFS_MCFG0, 32'h000E_FEAC);
      wr(`OFS_CTRL, 32'h0000_0005);
      rd(`OFS_MCFG0, `ZERO_WORD);
      wr(`OFS_SIGNATURE, `ZERO_WORD);
      rd(`OFS_SIGNATURE, {8'h00, sig[23:0]});
      rd(12'h020, `ZERO_WORD);
      wr(`OFS_CTRL, 32'h0000_0002);
      rd(`OFS_SIGNATURE, `ZERO_WORD);
      rd(`OFS_MCFG0, `ZERO_WORD);
      rd(`OFS_STATUS, `ZERO_WORD);
      pins({10'h000, 10'h3FF});
      wrap_up();
   end
endmodule
`default_nettype wire
